//--- hdl/apc_pkg.sv
package apc_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL2 = 8'h00;
  localparam logic [7:0] ADDR_CTRL5 = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_PORT = 8'h10;
  localparam logic [7:0] ADDR_RESULT0 = 8'h14;
  localparam logic [7:0] ADDR_POWER = 8'h18;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTL2_PWR_BIT = 7;
  localparam int CTL2_FFC_BIT = 6;
  localparam int CTL2_HALT_BIT = 2;
  localparam int CTL2_STOPW_BIT = 1;
  localparam int CTL2_IE_BIT = 0;
  localparam int CTL5_SCAN_BIT = 5;
  localparam int ST_SEQ_BIT = 0;
  localparam int ST_IRQ_BIT = 1;
  localparam int PWR_WAIT_BIT = 0;
  localparam int PWR_STOP_BIT = 1;

  // ---------------------------------------------------------------
  // reset values and sizes
  // ---------------------------------------------------------------
  localparam logic [7:0] CTL2_RESET = 8'h00;
  localparam logic [7:0] CTL5_RESET = 8'h00;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h3;
  localparam logic [3:0] SEQ_LEN_RESET = 4'h4;
  localparam int SEQ_CNT_W = 4;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic power_up;
    logic stop_clock_in_wait;
    logic halt_in_wait;
    logic irq_enable;
    logic fast_flag_clear;
  } apc_ctrl_type;

  typedef struct packed {
    logic sequence_done;
    logic converting;
  } apc_seq_type;

  typedef enum logic [1:0] {
    APC_RESP_OKAY = 2'b00,
    APC_RESP_SLVERR = 2'b10
  } apc_resp_type;

endpackage

//--- hdl/apc_sequencer.sv
`timescale 1ns/1ps
module apc_sequencer #(
  parameter int SEQ_W = apc_pkg::SEQ_CNT_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // control
  input wire logic clk_en,
  input wire logic start,
  input wire logic abort,
  input wire logic scan,
  input wire logic [SEQ_W-1:0] seq_len,
  // status
  output apc_pkg::apc_seq_type seq
);

  typedef enum logic [1:0] {APC_IDLE, APC_RUN} apc_state_type;

  apc_state_type state_r, state_nxt;
  logic [SEQ_W-1:0] cnt_r, cnt_nxt;
  logic done_r, done_nxt;

  // step through one conversion per enabled clock, pulse done at end
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (abort) begin
      state_nxt = APC_IDLE;
      cnt_nxt = '0;
    end else if (start) begin
      state_nxt = APC_RUN;
      cnt_nxt = '0;
    end else begin
      unique case (state_r)
        APC_IDLE: begin
          cnt_nxt = cnt_r;
        end
        APC_RUN: begin
          if (clk_en) begin
            if (cnt_r >= seq_len - SEQ_W'(1)) begin
              done_nxt = 1'b1;
              cnt_nxt = '0;
              state_nxt = scan ? APC_RUN : APC_IDLE;
            end else begin
              cnt_nxt = cnt_r + SEQ_W'(1);
            end
          end
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= APC_IDLE;
      cnt_r <= '0;
      done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign seq.sequence_done = done_r;
  assign seq.converting = (state_r == APC_RUN);

endmodule

//--- hdl/apc_top.sv
`timescale 1ns/1ps
// Behaviour
// R1: with analog_power_up clear the converter clock stops and analog is off, registers stay usable.
// R2: in wait mode with stop_clock_in_wait clear the converter runs as in run mode.
// R3: in wait mode with stop_clock_in_wait set the clock gate drops; conversion halts only with halt_in_wait.
// R4: in stop mode the converter is inactive and any running sequence is aborted.
// R5: sequence_done_irq_flag sets only on sequence completion while sequence_done_irq_enable is set.
// R6: the analog port is input-only and feeds the converter while powered.
// R7: with the converter powered down the port pins read as digital inputs; in stop with power_up set the code keeps them on the converter.
// R8: the pin-level register returns live pin levels and ignores writes.
// R9: sequence_complete_flag sets at end of a single sequence, or of the first continuous one.
// R10: sequence_complete_flag clears on a converter_control_five write, or on result read with fast_flag_clear.
// R11: the interrupt request is high while the flag and its enable are both set; the code drives it from both status bits under mask_r, gated by irq_enable.
module apc_top #(
  parameter int PORT_W = 8
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // axi4-lite write address
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // axi4-lite write data
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // axi4-lite write response
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read address
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // axi4-lite read data
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // analog port pins
  input wire logic [PORT_W-1:0] ANALOG_PORT_PIN_BITS,
  // cpu power state
  input wire logic CPU_WAIT,
  input wire logic CPU_STOP,
  // converter side
  output logic CONVERTER_CLK_EN,
  output logic ANALOG_POWER_EN,
  output logic [PORT_W-1:0] ANALOG_INPUT_SEL,
  // interrupt
  output logic IRQ
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  apc_pkg::apc_ctrl_type ctrl_r, ctrl_nxt;
  logic scan_r, scan_nxt;
  logic [apc_pkg::SEQ_CNT_W-1:0] seq_len_r, seq_len_nxt;
  logic seq_flag_r, seq_flag_nxt;
  logic [1:0] status_r, status_nxt;
  logic [1:0] mask_r, mask_nxt;
  logic first_r, first_nxt;
  logic clk_en_r, clk_en_nxt;
  logic pwr_r, pwr_nxt;
  logic [PORT_W-1:0] sel_r, sel_nxt;
  logic irq_r, irq_nxt;

  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [7:0] awaddr_r, awaddr_nxt;
  logic have_aw_r, have_aw_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic have_w_r, have_w_nxt;

  apc_pkg::apc_seq_type seq;
  logic wr_fire;
  logic rd_fire;
  logic start_seq;
  logic abort_seq;
  logic conv_run;
  logic hold_seq;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic addr_known(input logic [7:0] a);
    return a == apc_pkg::ADDR_CTRL2 || a == apc_pkg::ADDR_CTRL5 ||
           a == apc_pkg::ADDR_STATUS || a == apc_pkg::ADDR_IRQ_MASK ||
           a == apc_pkg::ADDR_PORT || a == apc_pkg::ADDR_RESULT0 ||
           a == apc_pkg::ADDR_POWER;
  endfunction

  // ---------------------------------------------------------------
  // power and clock gating
  // ---------------------------------------------------------------
  // converter runs when powered, not stopped, and not halted in wait
  always_comb begin
    conv_run = ctrl_r.power_up && !CPU_STOP; // [R1] [R4]
    hold_seq = CPU_WAIT && ctrl_r.stop_clock_in_wait && ctrl_r.halt_in_wait; // [R3]
    clk_en_nxt = conv_run && !(CPU_WAIT && ctrl_r.stop_clock_in_wait); // [R2] [R3]
    pwr_nxt = conv_run; // [R1] [R4]
    // pins go to the converter while power_up is set, even in stop with analog power off, else pure digital inputs
    sel_nxt = ctrl_r.power_up ? {PORT_W{1'b1}} : '0; // [R6] [R7]
    abort_seq = !ctrl_r.power_up || CPU_STOP; // [R4]
  end

  apc_sequencer #(
    .SEQ_W(apc_pkg::SEQ_CNT_W)
  ) u_seq (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .clk_en(conv_run && !hold_seq),
    .start(start_seq),
    .abort(abort_seq),
    .scan(scan_r),
    .seq_len(seq_len_r),
    .seq(seq)
  );

  // ---------------------------------------------------------------
  // axi4-lite handshake
  // ---------------------------------------------------------------
  assign wr_fire = have_aw_r && have_w_r && !bvalid_r;
  assign rd_fire = S_AXI_ARVALID && arready_r;
  assign start_seq = wr_fire && awaddr_r == apc_pkg::ADDR_CTRL5 && wstrb_r[0] &&
                     ctrl_r.power_up && !CPU_STOP;

  // capture address and data in either order, answer after both
  always_comb begin
    awaddr_nxt = awaddr_r;
    have_aw_nxt = have_aw_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    have_w_nxt = have_w_r;
    awready_nxt = awready_r;
    wready_nxt = wready_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (S_AXI_AWVALID && awready_r) begin
      awaddr_nxt = S_AXI_AWADDR;
      have_aw_nxt = 1'b1;
      awready_nxt = 1'b0;
    end
    if (S_AXI_WVALID && wready_r) begin
      wdata_nxt = S_AXI_WDATA;
      wstrb_nxt = S_AXI_WSTRB;
      have_w_nxt = 1'b1;
      wready_nxt = 1'b0;
    end
    if (wr_fire) begin
      have_aw_nxt = 1'b0;
      have_w_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = addr_known(awaddr_r) ? apc_pkg::APC_RESP_OKAY : apc_pkg::APC_RESP_SLVERR;
    end
    if (bvalid_r && S_AXI_BREADY) begin
      bvalid_nxt = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt = 1'b1;
    end
  end

  // read: one cycle after address to data
  always_comb begin
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rd_fire) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rresp_nxt = addr_known(S_AXI_ARADDR) ? apc_pkg::APC_RESP_OKAY : apc_pkg::APC_RESP_SLVERR;
      rdata_nxt = '0;
      unique case (S_AXI_ARADDR)
        apc_pkg::ADDR_CTRL2: begin
          rdata_nxt[apc_pkg::CTL2_PWR_BIT] = ctrl_r.power_up;
          rdata_nxt[apc_pkg::CTL2_FFC_BIT] = ctrl_r.fast_flag_clear;
          rdata_nxt[apc_pkg::CTL2_HALT_BIT] = ctrl_r.halt_in_wait;
          rdata_nxt[apc_pkg::CTL2_STOPW_BIT] = ctrl_r.stop_clock_in_wait;
          rdata_nxt[apc_pkg::CTL2_IE_BIT] = ctrl_r.irq_enable;
        end
        apc_pkg::ADDR_CTRL5: begin
          rdata_nxt[apc_pkg::CTL5_SCAN_BIT] = scan_r;
          rdata_nxt[apc_pkg::SEQ_CNT_W-1:0] = seq_len_r;
        end
        apc_pkg::ADDR_STATUS: begin
          rdata_nxt[1:0] = status_r;
          rdata_nxt[8] = seq_flag_r;
          rdata_nxt[9] = seq.converting;
        end
        apc_pkg::ADDR_IRQ_MASK: begin
          rdata_nxt[1:0] = mask_r;
        end
        apc_pkg::ADDR_PORT: begin
          rdata_nxt[PORT_W-1:0] = ANALOG_PORT_PIN_BITS; // [R8] [R7]
        end
        apc_pkg::ADDR_POWER: begin
          rdata_nxt[apc_pkg::PWR_WAIT_BIT] = CPU_WAIT;
          rdata_nxt[apc_pkg::PWR_STOP_BIT] = CPU_STOP;
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end
    if (rvalid_r && S_AXI_RREADY) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // control registers and flags
  // ---------------------------------------------------------------
  // software writes, sequence flags; set wins over clear
  always_comb begin
    logic res_read;
    logic w1c_seq;
    logic w1c_irq;
    res_read = rd_fire && S_AXI_ARADDR == apc_pkg::ADDR_RESULT0;
    w1c_seq = 1'b0;
    w1c_irq = 1'b0;
    ctrl_nxt = ctrl_r;
    scan_nxt = scan_r;
    seq_len_nxt = seq_len_r;
    mask_nxt = mask_r;
    first_nxt = first_r;
    seq_flag_nxt = seq_flag_r;
    status_nxt = status_r;
    if (wr_fire && wstrb_r[0]) begin
      unique case (awaddr_r)
        apc_pkg::ADDR_CTRL2: begin
          ctrl_nxt.power_up = wdata_r[apc_pkg::CTL2_PWR_BIT];
          ctrl_nxt.fast_flag_clear = wdata_r[apc_pkg::CTL2_FFC_BIT];
          ctrl_nxt.halt_in_wait = wdata_r[apc_pkg::CTL2_HALT_BIT];
          ctrl_nxt.stop_clock_in_wait = wdata_r[apc_pkg::CTL2_STOPW_BIT];
          ctrl_nxt.irq_enable = wdata_r[apc_pkg::CTL2_IE_BIT];
        end
        apc_pkg::ADDR_CTRL5: begin
          scan_nxt = wdata_r[apc_pkg::CTL5_SCAN_BIT];
          seq_len_nxt = wdata_r[apc_pkg::SEQ_CNT_W-1:0];
        end
        apc_pkg::ADDR_STATUS: begin
          w1c_seq = wdata_r[apc_pkg::ST_SEQ_BIT];
          w1c_irq = wdata_r[apc_pkg::ST_IRQ_BIT];
        end
        apc_pkg::ADDR_IRQ_MASK: begin
          mask_nxt = wdata_r[1:0];
        end
        default: begin
          mask_nxt = mask_r; // port and result ignore writes [R8]
        end
      endcase
    end
    // sequence complete flag
    if (wr_fire && awaddr_r == apc_pkg::ADDR_CTRL5 && wstrb_r[0]) begin
      seq_flag_nxt = 1'b0; // [R10]
      first_nxt = 1'b1;
    end else if (res_read && ctrl_r.fast_flag_clear) begin
      seq_flag_nxt = 1'b0; // [R10]
    end
    if (seq.sequence_done && first_r) begin
      seq_flag_nxt = 1'b1; // [R9]
      first_nxt = 1'b0;
    end
    // sticky status: bit0 sequence complete, bit1 irq flag
    if (w1c_seq) begin
      status_nxt[apc_pkg::ST_SEQ_BIT] = 1'b0;
    end
    if (w1c_irq) begin
      status_nxt[apc_pkg::ST_IRQ_BIT] = 1'b0;
    end
    if (seq.sequence_done) begin
      status_nxt[apc_pkg::ST_SEQ_BIT] = 1'b1;
      if (ctrl_r.irq_enable) begin
        status_nxt[apc_pkg::ST_IRQ_BIT] = 1'b1; // [R5]
      end
    end
    // interrupt from masked sticky status gated by irq_enable
    irq_nxt = |(status_nxt & mask_nxt) && ctrl_nxt.irq_enable; // [R11] [R5]
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_r <= '0;
      scan_r <= 1'b0;
      seq_len_r <= apc_pkg::SEQ_LEN_RESET;
      mask_r <= apc_pkg::IRQ_MASK_RESET;
      first_r <= 1'b0;
      seq_flag_r <= 1'b0;
      status_r <= 2'h0;
      clk_en_r <= 1'b0;
      pwr_r <= 1'b0;
      sel_r <= '0;
      irq_r <= 1'b0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= 2'h0;
      awaddr_r <= 8'h0;
      have_aw_r <= 1'b0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      have_w_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      scan_r <= scan_nxt;
      seq_len_r <= seq_len_nxt;
      mask_r <= mask_nxt;
      first_r <= first_nxt;
      seq_flag_r <= seq_flag_nxt;
      status_r <= status_nxt;
      clk_en_r <= clk_en_nxt;
      pwr_r <= pwr_nxt;
      sel_r <= sel_nxt;
      irq_r <= irq_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      awaddr_r <= awaddr_nxt;
      have_aw_r <= have_aw_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      have_w_r <= have_w_nxt;
    end
  end

  // outputs straight from flops
  assign S_AXI_AWREADY = awready_r;
  assign S_AXI_WREADY = wready_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = arready_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;
  assign CONVERTER_CLK_EN = clk_en_r;
  assign ANALOG_POWER_EN = pwr_r;
  assign ANALOG_INPUT_SEL = sel_r;
  assign IRQ = irq_r;

endmodule

//--- tb/adc_power_irq_port_control_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
// ----------------------------------------
// bench top
// ----------------------------------------
module adc_power_irq_port_control_tb_top;
  logic ref_clk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, cpu_wait, cpu_stop, clk_en, pwr_en, irq;
  logic [7:0] awaddr, araddr, pins, sel;
  logic [31:0] wdata, rdata, rdat;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  apc_top dut_u (
    .REF_CLK(ref_clk), .ARST_N(arst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .ANALOG_PORT_PIN_BITS(pins), .CPU_WAIT(cpu_wait), .CPU_STOP(cpu_stop),
    .CONVERTER_CLK_EN(clk_en), .ANALOG_POWER_EN(pwr_en), .ANALOG_INPUT_SEL(sel), .IRQ(irq)
  );
  apc_cpu_model cpu_u (
    .clk(ref_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );

  // clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic complete_run();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk_rd(input string n, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    cpu_u.rd(a, rdat);
    `CHK(n, e, rdat & m)
  endtask
  // poll the live sequence-complete flag with a bounded number of reads
  task automatic poll_done();
    rdat = '0;
    for (int i = 0; i < 60 && rdat[8] !== 1'b1; i++) cpu_u.rd(apc_pkg::ADDR_STATUS, rdat);
    `CHK("seq_flag", 1'b1, rdat[8])
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    `CHK("clk_en", 1'b0, clk_en)
    `CHK("irq", 1'b0, irq)
    chk_rd("ctrl2", apc_pkg::ADDR_CTRL2, 32'hffffffff, 32'h0);
    chk_rd("ctrl5", apc_pkg::ADDR_CTRL5, 32'hffffffff, 32'h4);
    chk_rd("mask", apc_pkg::ADDR_IRQ_MASK, 32'hffffffff, 32'h3);
    chk_rd("status", apc_pkg::ADDR_STATUS, 32'hffffffff, 32'h0);
  endtask
  task automatic t_port();
    pins <= 8'ha5;
    tick(3);
    chk_rd("port", apc_pkg::ADDR_PORT, 32'hffffffff, 32'ha5);
    `CHK("sel", 8'h00, sel)
    cpu_u.wr(apc_pkg::ADDR_PORT, 32'h5a);
    `CHK("port_wr", 2'h0, cpu_u.last_resp)
    chk_rd("port", apc_pkg::ADDR_PORT, 32'hffffffff, 32'ha5);
    cpu_u.wr(8'h1c, 32'h0);
    `CHK("unmapped_wr", 2'h2, cpu_u.last_resp)
    cpu_u.rd(8'h1c, rdat);
    `CHK("unmapped", {2'h2, 32'h0}, {cpu_u.last_resp, rdat})
  endtask
  task automatic t_power();
    cpu_u.wr(apc_pkg::ADDR_CTRL2, 32'h80);
    tick(2);
    `CHK("clk_en", 1'b1, clk_en)
    `CHK("sel", 8'hff, sel)
    pins <= 8'h3c;
    tick(3);
    chk_rd("port", apc_pkg::ADDR_PORT, 32'hffffffff, 32'h3c);
    cpu_u.wr(apc_pkg::ADDR_CTRL2, 32'h45);
    tick(2);
    `CHK("power", 2'b00, {pwr_en, clk_en})
    chk_rd("ctrl2", apc_pkg::ADDR_CTRL2, 32'hffffffff, 32'h45);
  endtask
  task automatic t_seq();
    cpu_u.wr(apc_pkg::ADDR_CTRL2, 32'h81);
    cpu_u.wr(apc_pkg::ADDR_CTRL5, 32'h03);
    poll_done();
    chk_rd("status", apc_pkg::ADDR_STATUS, 32'h303, 32'h103);
    tick(1);
    `CHK("irq", 1'b1, irq)
    cpu_u.wr(apc_pkg::ADDR_IRQ_MASK, 32'h0);
    tick(2);
    `CHK("irq_masked", 1'b0, irq)
    cpu_u.wr(apc_pkg::ADDR_IRQ_MASK, 32'h3);
    cpu_u.wr(apc_pkg::ADDR_STATUS, 32'h3);
    tick(2);
    `CHK("irq_clr", 1'b0, irq)
    cpu_u.wr(apc_pkg::ADDR_CTRL5, 32'h0f);
    chk_rd("flag_clr", apc_pkg::ADDR_STATUS, 32'h100, 32'h0);
    poll_done();
    cpu_u.wr(apc_pkg::ADDR_CTRL2, 32'h80);
    cpu_u.wr(apc_pkg::ADDR_STATUS, 32'h3);
    cpu_u.wr(apc_pkg::ADDR_CTRL5, 32'h03);
    poll_done();
    chk_rd("no_ie", apc_pkg::ADDR_STATUS, 32'h3, 32'h1);
    `CHK("irq_off", 1'b0, irq)
    cpu_u.wr(apc_pkg::ADDR_CTRL5, 32'h21);
    poll_done();
    cpu_u.wr(apc_pkg::ADDR_STATUS, 32'h3);
    tick(10);
    chk_rd("scan", apc_pkg::ADDR_STATUS, 32'h101, 32'h101);
    cpu_u.wr(apc_pkg::ADDR_CTRL2, 32'hc0);
    cpu_u.rd(apc_pkg::ADDR_RESULT0, rdat);
    chk_rd("fast_clr", apc_pkg::ADDR_STATUS, 32'h100, 32'h0);
    cpu_u.wr(apc_pkg::ADDR_CTRL2, 32'h0);
  endtask
  task automatic t_wait();
    cpu_wait <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      cpu_u.wr(apc_pkg::ADDR_CTRL2, i ? 32'h82 : 32'h80);
      cpu_u.wr(apc_pkg::ADDR_CTRL5, 32'h03);
      poll_done();
      `CHK("wait_clk", i == 0, clk_en)
    end
    cpu_u.wr(apc_pkg::ADDR_CTRL2, 32'h86);
    cpu_u.wr(apc_pkg::ADDR_CTRL5, 32'h0f);
    tick(40);
    chk_rd("halted", apc_pkg::ADDR_STATUS, 32'h300, 32'h200);
    chk_rd("pstate", apc_pkg::ADDR_POWER, 32'h3, 32'h1);
    cpu_wait <= 1'b0;
    poll_done();
  endtask
  task automatic t_stop();
    cpu_u.wr(apc_pkg::ADDR_CTRL2, 32'h80);
    cpu_u.wr(apc_pkg::ADDR_STATUS, 32'h3);
    cpu_u.wr(apc_pkg::ADDR_CTRL5, 32'h0f);
    cpu_stop <= 1'b1;
    tick(3);
    `CHK("stop_clk", 1'b0, clk_en)
    `CHK("stop_pwr", 9'h0ff, {pwr_en, sel})
    chk_rd("aborted", apc_pkg::ADDR_STATUS, 32'h301, 32'h0);
    cpu_stop <= 1'b0;
    tick(40);
    chk_rd("no_resume", apc_pkg::ADDR_STATUS, 32'h301, 32'h0);
  endtask

  // main sequence
  initial begin
    arst_n = 1'b0;
    cpu_wait = 1'b0;
    cpu_stop = 1'b0;
    pins = 8'h00;
    tick(10);
    arst_n <= 1'b1;
    t_reset();
    t_port();
    t_power();
    t_seq();
    t_wait();
    t_stop();
    complete_run();
  end
endmodule

//--- tb/apc_cpu_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// register bus master standing in for the cpu core
// ----------------------------------------
module apc_cpu_model (
  // clock
  input wire logic clk,
  // write channels
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // read channels
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  logic [1:0] last_resp;

  // idle bus at time zero
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    last_resp = 2'h0;
  end

  // one write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_p;
    logic w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge clk);
      if (aw_p && awready) begin
        awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && wready) begin
        wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk);
    last_resp = bresp;
    bready <= 1'b0;
  endtask

  // one read: address held until taken, data taken at the handshake edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    d = rdata;
    last_resp = rresp;
    rready <= 1'b0;
  endtask
endmodule

//--- tb/apc_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker for the control slice
// ----------------------------------------
module apc_monitor #(
  parameter int PORT_W = 8
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic ARST_N,
  // register bus
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // cpu state and converter side
  input wire logic CPU_STOP,
  input wire logic CONVERTER_CLK_EN,
  input wire logic ANALOG_POWER_EN,
  input wire logic [PORT_W-1:0] ANALOG_INPUT_SEL
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);

  // stop drops analog power but leaves the pins with the converter, so skip that case
  a_pins_follow_power: assert property (
    !$past(CPU_STOP) |->
      ANALOG_INPUT_SEL == (ANALOG_POWER_EN ? {PORT_W{1'b1}} : {PORT_W{1'b0}}))
    else $error("input select disagrees with analog power");
  a_stop_power_off: assert property (CPU_STOP |=> !ANALOG_POWER_EN)
    else $error("analog power on in stop");
  a_gate_needs_power: assert property (CONVERTER_CLK_EN |-> ANALOG_POWER_EN)
    else $error("converter clock on without analog power");
  a_stop_gate_off: assert property (CPU_STOP |=> !CONVERTER_CLK_EN)
    else $error("converter clock running in stop");
  a_write_answer: assert property (
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID)
    else $error("write response late");
  a_bresp_held: assert property (
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data late");
  a_rdata_held: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  a_write_refused: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write accepted while response pending");
endmodule

bind apc_top apc_monitor #(.PORT_W(PORT_W)) mon_u (
  .REF_CLK(REF_CLK), .ARST_N(ARST_N),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .CPU_STOP(CPU_STOP), .CONVERTER_CLK_EN(CONVERTER_CLK_EN),
  .ANALOG_POWER_EN(ANALOG_POWER_EN), .ANALOG_INPUT_SEL(ANALOG_INPUT_SEL)
);
